// ### dof_pkg.sv
// Constants and carrier types for the dynamic offset and drive config block
package dof_pkg;
    // Sizes
    localparam int NUM_INPUTS = 14; // Sense inputs
    localparam int DATA_W = 16; // Measurement word width
    localparam int IDX_W = 4; // Sense input index width
    localparam int OFS_W = 8; // Offset tracking value width
    localparam int THR_W = 6; // Threshold code width
    localparam int IVAL_W = 6; // Interval code width
    localparam int YSCAN_W = 6; // Y scan field width
    localparam int PAIR_W = 2; // Reserved pair width
    localparam int NIB_W = 4; // Trim and reserved nibble width
    // Register offsets
    localparam logic [7:0] ADDR_OFS_BASE = 8'h70;
    localparam logic [7:0] ADDR_THRESH = 8'h7E;
    localparam logic [7:0] ADDR_IVAL = 8'h7F;
    localparam logic [7:0] ADDR_XSCAN = 8'h80;
    localparam logic [7:0] ADDR_YSCAN = 8'h81;
    localparam logic [7:0] ADDR_RSV_ONE = 8'h82;
    localparam logic [7:0] ADDR_FREQ = 8'h83;
    // Field positions
    localparam int STEP_SEL_BIT = 7; // Step select in interval register
    localparam int TRIM_LSB = 4; // Trim field low bit
    localparam int X_FIRST_INPUT = 6; // Input served by x scan bit 0
    localparam int THRESH_SHIFT = 8; // Threshold code weight 256
    localparam int OFS_SHIFT = 7; // Offset code weight 128
    // Reset values
    localparam logic [THR_W-1:0] RST_THRESH = 6'h00;
    localparam logic [IVAL_W-1:0] RST_IVAL = 6'h00;
    localparam logic RST_STEP_SEL = 1'h0;
    localparam logic [7:0] RST_XSCAN = 8'h00;
    localparam logic [YSCAN_W-1:0] RST_YSCAN = 6'h00;
    localparam logic [PAIR_W-1:0] RST_PAIR = 2'h0;
    localparam logic [NIB_W-1:0] RST_TRIM = 4'h5;
    localparam logic [NIB_W-1:0] RST_NIBBLE = 4'h7;
    localparam logic [OFS_W-1:0] RST_OFS = 8'h00;
    // Step sizes
    localparam logic [OFS_W-1:0] STEP_SMALL = 8'h01;
    localparam logic [OFS_W-1:0] STEP_LARGE = 8'h02;
    // Register access request
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    // One measurement word tagged with its input
    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] input_idx;
        logic signed [DATA_W-1:0] data;
    } meas_t;
endpackage : dof_pkg

// ### dof_drive_config.sv
// Dynamic offset tracking, drive scan enables and drive trim registers
`timescale 1ns/100ps
module dof_drive_config #(
    parameter int NUM_INPUTS = dof_pkg::NUM_INPUTS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire dof_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire dof_pkg::meas_t meas,
    input wire logic signed [dof_pkg::DATA_W-1:0] data_center,
    input wire logic track_enable,
    input wire logic touch_panel_drive_enable,
    output dof_pkg::meas_t corrected,
    output logic [NUM_INPUTS-1:0] drive_pin_function,
    output logic [dof_pkg::NIB_W-1:0] drive_freq_trim,
    output logic [dof_pkg::PAIR_W-1:0] reserved_pair,
    output logic [dof_pkg::NIB_W-1:0] reserved_nibble
);
    import dof_pkg::*;

    localparam int EXT_W = DATA_W + 4; // Headroom for error sums
    // Signed limits of the corrected word
    localparam logic signed [EXT_W-1:0] CORR_MAX =
        EXT_W'({1'b0, {(DATA_W-1){1'b1}}});
    localparam logic signed [EXT_W-1:0] CORR_MIN = -CORR_MAX - EXT_W'(1);

    // Configuration fields
    logic [THR_W-1:0] track_threshold_code; // Window half width code
    logic [IVAL_W-1:0] track_interval_code; // Measurements per step less one
    logic track_step_select; // Larger step when set
    logic [7:0] x_drive_enable_bits; // Inputs 13 down to 6
    logic [YSCAN_W-1:0] y_drive_enable_bits; // Inputs 5 down to 0
    // Per-input tracking state
    logic [OFS_W-1:0] input_offset_track_value [NUM_INPUTS];
    logic [IVAL_W-1:0] meas_count [NUM_INPUTS];

    // Write decode
    logic wr_thresh;
    logic wr_ival;
    logic wr_xscan;
    logic wr_yscan;
    logic wr_pair;
    logic wr_freq;
    logic wr_ofs; // Write lands in the offset array
    logic [IDX_W-1:0] wr_ofs_idx; // Target entry of that write

    // Tracking datapath
    logic meas_known; // Input index is in range
    logic [OFS_W-1:0] sel_ofs; // Offset of measured input
    logic [IVAL_W-1:0] sel_count; // Count of measured input
    logic signed [EXT_W-1:0] meas_ext;
    logic signed [EXT_W-1:0] center_ext;
    logic signed [EXT_W-1:0] ofs_scaled;
    logic signed [EXT_W-1:0] err; // Corrected minus center
    logic [EXT_W-1:0] err_abs;
    logic [EXT_W-1:0] thr_scaled;
    logic in_window; // Error inside threshold
    logic interval_done; // This measurement ends the interval
    logic do_step; // Offset moves this cycle
    logic [OFS_W-1:0] step_size;
    logic signed [OFS_W:0] step_sum; // One extra bit to see overflow
    logic [OFS_W-1:0] next_ofs; // Saturated stepped value
    logic signed [EXT_W-1:0] corr_sum;
    logic signed [DATA_W-1:0] next_corr;
    logic [7:0] next_rdata;

    // Address decode of the register port
    // Offset window holds one entry per input
    always_comb begin
        wr_thresh = reg_req.write && (reg_req.addr == ADDR_THRESH);
        wr_ival = reg_req.write && (reg_req.addr == ADDR_IVAL);
        wr_xscan = reg_req.write && (reg_req.addr == ADDR_XSCAN);
        wr_yscan = reg_req.write && (reg_req.addr == ADDR_YSCAN);
        wr_pair = reg_req.write && (reg_req.addr == ADDR_RSV_ONE);
        wr_freq = reg_req.write && (reg_req.addr == ADDR_FREQ);
        wr_ofs = reg_req.write && (reg_req.addr >= ADDR_OFS_BASE)
            && (reg_req.addr < ADDR_OFS_BASE + 8'(NUM_INPUTS));
        wr_ofs_idx = IDX_W'(reg_req.addr - ADDR_OFS_BASE);
    end

    // Threshold and interval registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            track_threshold_code <= RST_THRESH;
            track_interval_code <= RST_IVAL;
            track_step_select <= RST_STEP_SEL;
        end else begin
            // Unused high bits of these registers are dropped
            // Step select shares the interval register
            if (wr_thresh) begin
                track_threshold_code <= reg_req.wdata[THR_W-1:0];
            end
            if (wr_ival) begin
                track_interval_code <= reg_req.wdata[IVAL_W-1:0];
                track_step_select <= reg_req.wdata[STEP_SEL_BIT];
            end
        end
    end

    // Scan, reserved and trim registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            x_drive_enable_bits <= RST_XSCAN;
            y_drive_enable_bits <= RST_YSCAN;
            reserved_pair <= RST_PAIR;
            drive_freq_trim <= RST_TRIM;
            reserved_nibble <= RST_NIBBLE;
        end else begin
            if (wr_xscan) begin
                x_drive_enable_bits <= reg_req.wdata;
            end
            if (wr_yscan) begin
                y_drive_enable_bits <= reg_req.wdata[YSCAN_W-1:0];
            end
            // Stored as written; host keeps it at zero
            if (wr_pair) begin
                reserved_pair <= reg_req.wdata[PAIR_W-1:0];
            end
            // Trim goes straight to the drive oscillator
            if (wr_freq) begin
                drive_freq_trim <= reg_req.wdata[TRIM_LSB +: NIB_W];
                reserved_nibble <= reg_req.wdata[NIB_W-1:0];
            end
        end
    end

    // Select state of the input being measured
    // Inputs out of range see zero offset and count
    always_comb begin
        meas_known = (meas.input_idx < IDX_W'(NUM_INPUTS));
        sel_ofs = RST_OFS;
        sel_count = '0;
        if (meas_known) begin
            sel_ofs = input_offset_track_value[meas.input_idx];
            sel_count = meas_count[meas.input_idx];
        end
    end

    // Corrected error against the data center
    always_comb begin
        meas_ext = EXT_W'(meas.data);
        center_ext = EXT_W'(data_center);
        // Offset code weighs 128 per count
        ofs_scaled = EXT_W'($signed(sel_ofs)) <<< OFS_SHIFT;
        err = meas_ext - center_ext + ofs_scaled;
        err_abs = err[EXT_W-1] ? EXT_W'(-err) : EXT_W'(err);
        thr_scaled = EXT_W'(track_threshold_code) << THRESH_SHIFT;
        in_window = (err_abs <= thr_scaled);
    end

    // Step decision and saturating step
    always_comb begin
        interval_done = (sel_count == track_interval_code);
        do_step = meas.valid && meas_known && track_enable
            && interval_done && in_window;
        step_size = track_step_select ? STEP_LARGE : STEP_SMALL;
        // Below center: raise offset; above: lower it
        if (err[EXT_W-1]) begin
            step_sum = $signed({sel_ofs[OFS_W-1], sel_ofs})
                + $signed({1'b0, step_size});
        end else if (err != '0) begin
            step_sum = $signed({sel_ofs[OFS_W-1], sel_ofs})
                - $signed({1'b0, step_size});
        end else begin
            // Exactly on center: hold the value
            step_sum = $signed({sel_ofs[OFS_W-1], sel_ofs});
        end
        // Clamp at the two's complement ends
        if (step_sum[OFS_W] != step_sum[OFS_W-1]) begin
            next_ofs = step_sum[OFS_W] ? {1'b1, {(OFS_W-1){1'b0}}}
                : {1'b0, {(OFS_W-1){1'b1}}};
        end else begin
            next_ofs = step_sum[OFS_W-1:0];
        end
    end

    // Per-input offset and measurement counter
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_track
        logic hit; // Measurement for this input
        assign hit = meas.valid && meas_known
            && (meas.input_idx == IDX_W'(i));

        // Interval counter restarts after each completed interval
        // Words for other inputs leave this counter alone
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meas_count[i] <= '0;
            end else if (!track_enable) begin
                meas_count[i] <= '0;
            end else if (hit) begin
                if (interval_done) begin
                    meas_count[i] <= '0;
                end else begin
                    meas_count[i] <= meas_count[i] + IVAL_W'(1);
                end
            end
        end

        // Hardware step wins over a host write in the same cycle
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                input_offset_track_value[i] <= RST_OFS;
            end else if (do_step && hit) begin
                input_offset_track_value[i] <= next_ofs;
            end else if (wr_ofs && (wr_ofs_idx == IDX_W'(i))) begin
                input_offset_track_value[i] <= reg_req.wdata;
            end
        end
    end

    // Drive pin function per input, gated by panel drive
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_drive
        logic en_bit; // Scan bit owning this input
        if (i < X_FIRST_INPUT) begin : g_y
            assign en_bit = y_drive_enable_bits[i];
        end else begin : g_x
            assign en_bit = x_drive_enable_bits[i-X_FIRST_INPUT];
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                drive_pin_function[i] <= 1'b0;
            end else begin
                drive_pin_function[i] <= touch_panel_drive_enable
                    && en_bit;
            end
        end
    end

    // Offset applied to the converter result, clamped to word size
    always_comb begin
        corr_sum = track_enable ? meas_ext + ofs_scaled : meas_ext;
        // Both bounds signed, else negative sums read as huge
        if (corr_sum > CORR_MAX) begin
            next_corr = DATA_W'(CORR_MAX);
        end else if (corr_sum < CORR_MIN) begin
            next_corr = DATA_W'(CORR_MIN);
        end else begin
            next_corr = corr_sum[DATA_W-1:0];
        end
    end

    // Corrected measurement output register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            corrected <= '0;
        end else begin
            corrected.valid <= meas.valid;
            corrected.input_idx <= meas.input_idx;
            corrected.data <= next_corr;
        end
    end

    // Read mux; unused bits and unmapped offsets read zero, reserved fields read back
    // A read in a write cycle returns the old value
    always_comb begin
        next_rdata = 8'h00;
        if (reg_req.addr == ADDR_THRESH) begin
            next_rdata = 8'(track_threshold_code);
        end else if (reg_req.addr == ADDR_IVAL) begin
            next_rdata = 8'(track_interval_code);
            next_rdata[STEP_SEL_BIT] = track_step_select;
        end else if (reg_req.addr == ADDR_XSCAN) begin
            next_rdata = x_drive_enable_bits;
        end else if (reg_req.addr == ADDR_YSCAN) begin
            next_rdata = 8'(y_drive_enable_bits);
        end else if (reg_req.addr == ADDR_RSV_ONE) begin
            next_rdata = 8'(reserved_pair);
        end else if (reg_req.addr == ADDR_FREQ) begin
            next_rdata = {drive_freq_trim, reserved_nibble};
        end else if ((reg_req.addr >= ADDR_OFS_BASE)
            && (reg_req.addr < ADDR_OFS_BASE + 8'(NUM_INPUTS))) begin
            // Live tracking value as stepped by hardware
            next_rdata = input_offset_track_value[wr_ofs_idx];
        end
    end

    // Read data register, one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.read;
            if (reg_req.read) begin
                reg_rdata <= next_rdata;
            end
        end
    end
endmodule : dof_drive_config

// ### dof_drive_config_asserts.sv
// Port-level checks for the drive config block
`timescale 1ns/100ps
module dof_drive_config_asserts import dof_pkg::*; #(
    parameter int NUM_INPUTS = dof_pkg::NUM_INPUTS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire dof_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire dof_pkg::meas_t meas,
    input wire logic signed [dof_pkg::DATA_W-1:0] data_center,
    input wire logic track_enable,
    input wire logic touch_panel_drive_enable,
    input wire dof_pkg::meas_t corrected,
    input wire logic [NUM_INPUTS-1:0] drive_pin_function,
    input wire logic [dof_pkg::NIB_W-1:0] drive_freq_trim,
    input wire logic [dof_pkg::PAIR_W-1:0] reserved_pair,
    input wire logic [dof_pkg::NIB_W-1:0] reserved_nibble
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Scan write with drive enabled over two edges
    sequence x_wr_s;
        reg_req.write && reg_req.addr == ADDR_XSCAN
        ##1 touch_panel_drive_enable;
    endsequence
    sequence y_wr_s;
        reg_req.write && reg_req.addr == ADDR_YSCAN
        ##1 touch_panel_drive_enable;
    endsequence
    read_answer_a: assert property (reg_req.read |=> reg_rvalid)
        else $error("read not answered");
    read_cause_a: assert property (reg_rvalid |-> $past(reg_req.read))
        else $error("read valid without request");
    unmapped_read_a: assert property (reg_req.read &&
        reg_req.addr > ADDR_FREQ |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    trim_store_a: assert property (reg_req.write && reg_req.addr == ADDR_FREQ
        |=> drive_freq_trim == $past(reg_req.wdata[7:4]))
        else $error("trim field not stored");
    meas_follow_a: assert property (meas.valid |=> corrected.valid &&
        corrected.input_idx == $past(meas.input_idx))
        else $error("corrected word missing");
    corr_cause_a: assert property (corrected.valid |-> $past(meas.valid))
        else $error("corrected word without measurement");
    raw_pass_a: assert property (corrected.valid && (!$past(track_enable)
        || $past(meas.input_idx) >= NUM_INPUTS) |-> corrected.data
        == $past(meas.data))
        else $error("offset added while not tracking");
    pins_off_a: assert property (!$past(touch_panel_drive_enable)
        |-> drive_pin_function == '0)
        else $error("drive pins on while disabled");
    x_map_a: assert property (x_wr_s |=>
        drive_pin_function[13:6] == $past(reg_req.wdata, 2))
        else $error("x scan mapping wrong");
    y_map_a: assert property (y_wr_s |=>
        drive_pin_function[5:0] == $past(reg_req.wdata[5:0], 2))
        else $error("y scan mapping wrong");
endmodule : dof_drive_config_asserts
bind dof_drive_config dof_drive_config_asserts #(.NUM_INPUTS(NUM_INPUTS))
    chk (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .meas(meas),
    .data_center(data_center), .track_enable(track_enable),
    .touch_panel_drive_enable(touch_panel_drive_enable),
    .corrected(corrected), .drive_pin_function(drive_pin_function),
    .drive_freq_trim(drive_freq_trim), .reserved_pair(reserved_pair),
    .reserved_nibble(reserved_nibble));

// ### dof_host_model.sv
// Host controller model issuing register transfers
`timescale 1ns/100ps
module dof_host_model import dof_pkg::*; (
    input wire logic clk,
    output dof_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // Idle bus at time zero
    initial reg_req = '0;
    // One write, then the bus shows inverted junk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) reg_req <= '{1'b0, 1'b0, ~a, ~d};
        @(posedge clk);
    endtask : wr
    // One read, data taken with the valid pulse
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) reg_req <= '{1'b0, 1'b0, ~a, 8'hFF};
        @(posedge clk) d = reg_rvalid ? reg_rdata : 8'hXX;
    endtask : rd
    // Reserved fields at their mandatory values
    task automatic setup();
        wr(ADDR_RSV_ONE, 8'h00);
        wr(ADDR_FREQ, 8'h57);
    endtask : setup
endmodule : dof_host_model

// ### tb_dof_drive_config.sv
// Self-checking bench for the drive config block
`timescale 1ns/100ps
module tb_dof_drive_config;
    import dof_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic track_enable = 0;
    logic touch_panel_drive_enable = 0;
    logic signed [DATA_W-1:0] data_center = '0;
    meas_t meas = '0;
    reg_req_t reg_req;
    meas_t corrected;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [NUM_INPUTS-1:0] drive_pin_function;
    logic [NIB_W-1:0] drive_freq_trim;
    logic [NIB_W-1:0] reserved_nibble;
    logic [PAIR_W-1:0] reserved_pair;
    logic [7:0] x;
    logic [7:0] y;
    logic en;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int thr, ival, st; // Mirror of tracking setup
    int ofs_m[NUM_INPUTS] = '{default: 0}; // Expected offsets
    int cnt_m[NUM_INPUTS] = '{default: 0}; // Expected interval counts
    dof_drive_config uut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .meas(meas),
        .data_center(data_center), .track_enable(track_enable),
        .touch_panel_drive_enable(touch_panel_drive_enable),
        .corrected(corrected), .drive_pin_function(drive_pin_function),
        .drive_freq_trim(drive_freq_trim), .reserved_pair(reserved_pair),
        .reserved_nibble(reserved_nibble));
    dof_host_model host (.clk(clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    initial forever #4 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task automatic rchk(logic [7:0] a, logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk("register", e, v);
    endtask : rchk
    // Readable bits of each register but the reserved pair, left at FF
    function automatic logic [7:0] rmask(logic [7:0] a);
        case (a)
            ADDR_THRESH, ADDR_YSCAN: return 8'h3F;
            ADDR_IVAL: return 8'hBF;
            default: return 8'hFF;
        endcase
    endfunction : rmask
    task automatic cfg(int t, int v, int s);
        thr = t;
        ival = v;
        st = s ? 2 : 1;
        host.wr(ADDR_THRESH, 8'(t));
        host.wr(ADDR_IVAL, {s[0], 1'b0, v[5:0]});
    endtask : cfg
    // One measurement, its corrected word and the expected step
    task automatic send(int i, int d);
        int o, e;
        logic te;
        @(posedge clk) meas <= '{1'b1, 4'(i), 16'(d)};
        // Setup driven on earlier edges has settled by now
        te = track_enable && i < NUM_INPUTS;
        o = te ? ofs_m[i] : 0;
        e = d - data_center + o * 128;
        @(posedge clk) meas <= '{1'b0, ~4'(i), ~16'(d)};
        @(posedge clk);
        chk("corrected", 32'(d + o * 128), corrected.data);
        if (te) begin
            if (cnt_m[i] == ival) begin
                if ((e < 0 ? -e : e) <= thr * 256)
                    o = o + (e < 0 ? st : (e > 0 ? -st : 0));
                ofs_m[i] = o > 127 ? 127 : (o < -128 ? -128 : o);
                cnt_m[i] = 0;
            end else cnt_m[i]++;
        end
    endtask : send
    initial begin
        void'($urandom(32'hFB050CC9));
        repeat (4) @(posedge clk);
        rst_n <= 1;
        rchk(ADDR_FREQ, 8'h57);
        chk("trim", 5, drive_freq_trim);
        host.setup();
        chk("pair", 0, reserved_pair);
        chk("nibble", 7, reserved_nibble);
        for (int a = ADDR_THRESH; a <= ADDR_RSV_ONE; a++) begin
            x = (a == ADDR_RSV_ONE) ? 8'h00 : 8'($urandom);
            host.wr(8'(a), x);
            rchk(8'(a), x & rmask(8'(a)));
        end
        rchk(8'h90, 8'h00);
        $display("register test done");
        repeat (8) begin
            x = 8'($urandom);
            y = 8'($urandom);
            en = 1'($urandom);
            host.wr(ADDR_XSCAN, x);
            host.wr(ADDR_YSCAN, y);
            touch_panel_drive_enable <= en;
            repeat (3) @(posedge clk);
            chk("pins", en ? {x, y[5:0]} : 0, drive_pin_function);
        end
        for (int c = 0; c < 10; c++) begin
            host.wr(ADDR_FREQ, {4'(c), 4'h7});
            chk("trim", c, drive_freq_trim);
            chk("nibble", 7, reserved_nibble);
        end
        $display("drive test done");
        cfg(1, 0, 0);
        track_enable <= 1;
        send(5, 300);
        rchk(ADDR_OFS_BASE + 5, 8'h00);
        send(5, 256);
        rchk(ADDR_OFS_BASE + 5, 8'hFF);
        cfg(8'h3F, 0, 1);
        host.wr(ADDR_OFS_BASE + 2, 8'h7E);
        host.wr(ADDR_OFS_BASE + 3, 8'h81);
        ofs_m[2] = 126;
        ofs_m[3] = -127;
        ofs_m[5] = -1;
        send(2, -16300);
        send(3, 16300);
        rchk(ADDR_OFS_BASE + 2, 8'h7F);
        rchk(ADDR_OFS_BASE + 3, 8'h80);
        $display("threshold test done");
        cfg(8'h3F, $urandom_range(3, 0), $urandom_range(1, 0));
        data_center <= 16'($urandom_range(1000, 0) - 500);
        repeat (200) begin
            x = 8'($urandom_range(14, 0));
            send(x, $urandom_range(4000, 0) - 2000);
        end
        for (int i = 0; i < NUM_INPUTS; i++)
            rchk(ADDR_OFS_BASE + 8'(i), 8'(ofs_m[i]));
        track_enable <= 0;
        send(4, 1234);
        $display("tracking test done");
        final_report();
    end
endmodule : tb_dof_drive_config
